// ==== design/uswc_pkg.sv ====
package uswc_pkg;
  // Register byte addresses (printed offsets are word indices: byte address = index * 4)
  localparam logic [15:0] REG_BUS_CTRL_STATUS_IDX = 16'he680;
  localparam logic [15:0] REG_FORCE_SUSPEND_IDX = 16'he681;
  localparam logic [15:0] REG_WAKE_CTRL_STATUS_IDX = 16'he682;
  localparam logic [15:0] REG_POWER_CTRL_IDX = 16'he683;
  localparam logic [15:0] REG_EXT_IRQ_CTRL_IDX = 16'h00d8;
  localparam logic [15:0] REG_POWER_STATUS_IDX = 16'he684;
  localparam logic [17:0] ADDR_BUS_CTRL_STATUS = {REG_BUS_CTRL_STATUS_IDX, 2'b00};
  localparam logic [17:0] ADDR_FORCE_SUSPEND = {REG_FORCE_SUSPEND_IDX, 2'b00};
  localparam logic [17:0] ADDR_WAKE_CTRL_STATUS = {REG_WAKE_CTRL_STATUS_IDX, 2'b00};
  localparam logic [17:0] ADDR_POWER_CTRL = {REG_POWER_CTRL_IDX, 2'b00};
  localparam logic [17:0] ADDR_EXT_IRQ_CTRL = {REG_EXT_IRQ_CTRL_IDX, 2'b00};
  localparam logic [17:0] ADDR_POWER_STATUS = {REG_POWER_STATUS_IDX, 2'b00};

  // Field positions
  localparam int BCS_DRIVE_RESUME = 0;
  localparam int WCS_PIN_A_EN = 0;
  localparam int WCS_PIN_B_EN = 1;
  localparam int WCS_LINE_EN = 2;
  localparam int WCS_PIN_A_POL = 4;
  localparam int WCS_PIN_B_POL = 5;
  localparam int WCS_PIN_A_FLAG = 6;
  localparam int WCS_PIN_B_FLAG = 7;
  localparam int PCTL_IDLE = 0;
  localparam int EIC_WAKE_FLAG = 4;
  localparam int EIC_WAKE_EN = 5;

  // Reset value and writable-bit mask
  localparam logic [7:0] WCS_RESET = 8'h05;
  localparam logic [7:0] WCS_RW_MASK = 8'h37;

  // Interrupt identities
  localparam logic [7:0] SUSPEND_AUTOVECTOR = 8'h03;
  localparam logic [7:0] WAKE_VECTOR = 8'h33;

  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SUSPEND_IDLE_US = 3000;
  localparam int SUSPEND_IDLE_CYC = SUSPEND_IDLE_US * (CLK_HZ / 1_000_000);
  localparam int PLL_LOCK_CYC_DEFAULT = 16;

  typedef enum logic [1:0] {
    USWC_RUN,
    USWC_IDLE,
    USWC_OSC_OFF,
    USWC_PLL_WAIT
  } uswc_state_t;

  typedef struct packed {
    logic pin_a;
    logic pin_b;
    logic line_act;
  } uswc_wake_t;
endpackage

// ==== design/uswc_top.sv ====
// Function
// - Suspend interrupt after 3 ms bus idle
// - Bus idle suspend raises usb irq, autovector 3
// - Any write to force_suspend creates suspend
// - Idle bit stops oscillator when conditions hold
// - CPU in reset: bus suspend stops oscillator
// - Wake enables at b2, b1, b0
// - Pin polarities at b4, b5
// - Enabled line activity or pin edge wakes
// - Pin assertion sets its status flag while its wake enable is set
// - Pin status flags clear by writing one
// - Active wake pin keeps oscillator running
// - Wake waits PLL stable before irq
// - Wake irq dedicated, vector 0x33
// - Wake enable bit 5, flag bit 4
// - Wake irq disabled means no exit from oscillator stop unless CPU in reset
// - Service routine clears flag, CPU resumes
// - Only wake irq exits idle
// - Idle without suspend fires wake immediately
`timescale 1ns/1ps
`default_nettype none
module uswc_top #(
  parameter int SUSPEND_CYC = uswc_pkg::SUSPEND_IDLE_CYC,
  parameter int PLL_LOCK_CYC = uswc_pkg::PLL_LOCK_CYC_DEFAULT
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_idle_i,
  input wire logic usb_positive_line_i,
  input wire logic pin_a_i,
  input wire logic pin_b_i,
  input wire logic cpu_in_reset_i,
  input wire logic pll_locked_i,
  output logic usb_irq_line_o,
  output logic [7:0] usb_irq_vector_o,
  output logic wake_irq_o,
  output logic [7:0] wake_vector_o,
  output logic osc_enable_o,
  output logic cpu_idle_o,
  output logic usb_positive_line_o,
  output logic usb_negative_line_o,
  output logic usb_line_oe_o
);
  localparam int CW = 22;

  uswc_pkg::uswc_state_t state, next_state;
  logic [7:0] wcs;
  logic drive_resume;
  logic wake_irq_enable;
  logic wake_irq_flag;
  logic susp_irq_flag;
  logic bus_suspend;
  logic forced_suspend;
  logic [CW-1:0] idle_cnt;
  logic [CW-1:0] pll_cnt;
  logic pin_a_q, pin_b_q, line_q;
  logic [31:0] rd_data;

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_en = bus_req && wb_we_i && wb_sel_i[0];
  wire hit_bcs = (wb_adr_i == uswc_pkg::ADDR_BUS_CTRL_STATUS);
  wire hit_fs = (wb_adr_i == uswc_pkg::ADDR_FORCE_SUSPEND);
  wire hit_wcs = (wb_adr_i == uswc_pkg::ADDR_WAKE_CTRL_STATUS);
  wire hit_pc = (wb_adr_i == uswc_pkg::ADDR_POWER_CTRL);
  wire hit_eic = (wb_adr_i == uswc_pkg::ADDR_EXT_IRQ_CTRL);
  wire hit_ps = (wb_adr_i == uswc_pkg::ADDR_POWER_STATUS);
  wire wr_bcs = wr_en && hit_bcs;
  wire wr_fs = wr_en && hit_fs;
  wire wr_wcs = wr_en && hit_wcs;
  wire wr_pc = wr_en && hit_pc;
  wire wr_eic = wr_en && hit_eic;
  wire wr_ps = wr_en && hit_ps;

  // Wake sources
  wire pin_a_act = (pin_a_i == wcs[uswc_pkg::WCS_PIN_A_POL]);
  wire pin_b_act = (pin_b_i == wcs[uswc_pkg::WCS_PIN_B_POL]);
  wire pin_a_rise = pin_a_act && !pin_a_q;
  wire pin_b_rise = pin_b_act && !pin_b_q;
  wire line_rise = usb_positive_line_i && !line_q;
  wire pin_a_ev = pin_a_rise && wcs[uswc_pkg::WCS_PIN_A_EN];
  wire pin_b_ev = pin_b_rise && wcs[uswc_pkg::WCS_PIN_B_EN];
  wire line_ev = line_rise && wcs[uswc_pkg::WCS_LINE_EN];
  wire wake_ev = pin_a_ev || pin_b_ev || line_ev;
  // A live wake source blocks oscillator stop
  // D+ sits high in the J state, so the line only counts while the bus is active
  wire src_live = (wcs[uswc_pkg::WCS_PIN_A_EN] && pin_a_act)
               || (wcs[uswc_pkg::WCS_PIN_B_EN] && pin_b_act)
               || (wcs[uswc_pkg::WCS_LINE_EN] && !bus_idle_i)
               || pin_a_act || pin_b_act;
  wire suspend_cond = bus_suspend || forced_suspend;
  wire idle_set = wr_pc && wb_dat_i[uswc_pkg::PCTL_IDLE];
  wire idle_cnt_done = (idle_cnt == CW'(SUSPEND_CYC - 1));
  wire pll_done = pll_locked_i && (pll_cnt == CW'(PLL_LOCK_CYC - 1));
  wire wake_fire = (state == uswc_pkg::USWC_PLL_WAIT) && pll_done;
  // Idle with no suspend wakes at once
  wire instant_wake = (state == uswc_pkg::USWC_IDLE) && !suspend_cond;
  wire irq_clr = wr_eic && !wb_dat_i[uswc_pkg::EIC_WAKE_FLAG];
  wire susp_clr = wr_ps && wb_dat_i[0];

  always_comb begin
    next_state = state;
    case (state)
      uswc_pkg::USWC_RUN: begin
        if (idle_set) begin
          next_state = uswc_pkg::USWC_IDLE;
        end else if (cpu_in_reset_i && bus_suspend && !src_live) begin
          next_state = uswc_pkg::USWC_OSC_OFF;
        end
      end
      uswc_pkg::USWC_IDLE: begin
        // Only the wake path leaves idle; other interrupts are ignored
        if (instant_wake) begin
          next_state = uswc_pkg::USWC_RUN;
        end else if (wake_ev) begin
          next_state = uswc_pkg::USWC_PLL_WAIT;
        end else if (!src_live) begin
          next_state = uswc_pkg::USWC_OSC_OFF;
        end
      end
      uswc_pkg::USWC_OSC_OFF: begin
        // With the wake irq disabled there is no way out unless the CPU is in reset
        if (wake_ev && (wake_irq_enable || cpu_in_reset_i)) begin
          next_state = uswc_pkg::USWC_PLL_WAIT;
        end
      end
      default: begin
        if (pll_done) begin
          next_state = uswc_pkg::USWC_RUN;
        end
      end
    endcase
  end

  assign rd_data = hit_bcs ? {31'h0000_0000, drive_resume}
                 : hit_wcs ? {24'h00_0000, wcs}
                 : hit_pc ? {31'h0000_0000, cpu_idle_o}
                 : hit_eic ? {26'h000_0000, wake_irq_enable, wake_irq_flag, 4'h0}
                 : hit_ps ? {29'h0000_0000, forced_suspend, bus_suspend, susp_irq_flag}
                 : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= uswc_pkg::USWC_RUN;
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      line_q <= 1'b0;
      idle_cnt <= '0;
      pll_cnt <= '0;
    end else begin
      state <= next_state;
      pin_a_q <= pin_a_act;
      pin_b_q <= pin_b_act;
      line_q <= usb_positive_line_i;
      idle_cnt <= bus_idle_i ? (idle_cnt_done ? idle_cnt : idle_cnt + 1'b1) : '0;
      pll_cnt <= (state == uswc_pkg::USWC_PLL_WAIT && pll_locked_i && !pll_done) ?
                 pll_cnt + 1'b1 : '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_suspend <= 1'b0;
      susp_irq_flag <= 1'b0;
      forced_suspend <= 1'b0;
    end else begin
      bus_suspend <= bus_idle_i && idle_cnt_done;
      if (bus_idle_i && idle_cnt_done && !bus_suspend) begin
        susp_irq_flag <= 1'b1;
      end else if (susp_clr) begin
        susp_irq_flag <= 1'b0;
      end
      if (wr_fs) begin
        forced_suspend <= 1'b1;
      end else if (wake_fire || instant_wake) begin
        forced_suspend <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wcs <= uswc_pkg::WCS_RESET;
      drive_resume <= 1'b0;
      wake_irq_enable <= 1'b0;
      wake_irq_flag <= 1'b0;
    end else begin
      wcs[uswc_pkg::WCS_PIN_A_FLAG] <= (pin_a_act && wcs[uswc_pkg::WCS_PIN_A_EN])
        || (wcs[uswc_pkg::WCS_PIN_A_FLAG]
        && !(wr_wcs && wb_dat_i[uswc_pkg::WCS_PIN_A_FLAG]));
      wcs[uswc_pkg::WCS_PIN_B_FLAG] <= (pin_b_act && wcs[uswc_pkg::WCS_PIN_B_EN])
        || (wcs[uswc_pkg::WCS_PIN_B_FLAG]
        && !(wr_wcs && wb_dat_i[uswc_pkg::WCS_PIN_B_FLAG]));
      if (wr_wcs) begin
        wcs[5:0] <= wb_dat_i[5:0] & uswc_pkg::WCS_RW_MASK[5:0];
      end
      if (wr_bcs) begin
        drive_resume <= wb_dat_i[uswc_pkg::BCS_DRIVE_RESUME];
      end
      if (wr_eic) begin
        wake_irq_enable <= wb_dat_i[uswc_pkg::EIC_WAKE_EN];
      end
      // Set wins over a software clear in the same cycle
      if (wake_fire || instant_wake) begin
        wake_irq_flag <= 1'b1;
      end else if (irq_clr) begin
        wake_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      usb_irq_line_o <= 1'b0;
      usb_irq_vector_o <= 8'h00;
      wake_irq_o <= 1'b0;
      wake_vector_o <= 8'h00;
      osc_enable_o <= 1'b1;
      cpu_idle_o <= 1'b0;
      usb_positive_line_o <= 1'b0;
      usb_negative_line_o <= 1'b0;
      usb_line_oe_o <= 1'b0;
    end else begin
      usb_irq_line_o <= susp_irq_flag;
      usb_irq_vector_o <= susp_irq_flag ? uswc_pkg::SUSPEND_AUTOVECTOR : 8'h00;
      wake_irq_o <= wake_irq_flag && wake_irq_enable;
      wake_vector_o <= uswc_pkg::WAKE_VECTOR;
      osc_enable_o <= (next_state != uswc_pkg::USWC_OSC_OFF);
      cpu_idle_o <= (next_state != uswc_pkg::USWC_RUN);
      usb_positive_line_o <= 1'b0;
      usb_negative_line_o <= drive_resume;
      usb_line_oe_o <= drive_resume;
    end
  end

  a_osc_stop_cond: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(osc_enable_o) |-> $past(suspend_cond) && !$past(src_live))
    else $error("oscillator stopped without suspend");
  // An active pin, enabled or not, keeps a running oscillator from stopping in the next cycle
  a_pin_hold_osc: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (pin_a_act || pin_b_act) && osc_enable_o |=> osc_enable_o)
    else $error("oscillator stopped while pin active");
  a_forced_susp: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_fs |=> forced_suspend)
    else $error("force suspend write lost");
  a_forced_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wake_fire && !wr_fs |=> !forced_suspend)
    else $error("forced suspend kept after wake");
  a_susp_irq_vec: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    usb_irq_line_o |-> usb_irq_vector_o == uswc_pkg::SUSPEND_AUTOVECTOR)
    else $error("suspend vector wrong");
  a_usb_irq_line: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    susp_irq_flag |=> usb_irq_line_o)
    else $error("usb irq line not raised");
  a_susp_after_idle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    bus_idle_i && idle_cnt_done && !bus_suspend |=> susp_irq_flag)
    else $error("suspend irq missing after idle");
  a_susp_needs_idle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(bus_suspend) |-> $past(bus_idle_i))
    else $error("bus suspend without idle");
  a_wake_after_pll: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(wake_irq_flag) |-> $past(pll_done) || $past(instant_wake))
    else $error("wake irq before pll stable");
  a_no_flag_wait: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == uswc_pkg::USWC_PLL_WAIT && !pll_locked_i && !wake_irq_flag |=> !wake_irq_flag)
    else $error("wake flag while pll unlocked");
  a_fire_sets: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wake_fire |=> wake_irq_flag)
    else $error("wake flag not set after pll");
  a_wake_vec: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wake_irq_o |-> wake_vector_o == uswc_pkg::WAKE_VECTOR)
    else $error("wake vector wrong");
  a_wake_gate: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wake_irq_o |-> $past(wake_irq_enable))
    else $error("wake irq while disabled");
  a_ie_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_eic |=> wake_irq_enable == $past(wb_dat_i[uswc_pkg::EIC_WAKE_EN]))
    else $error("wake enable write lost");
  a_flag_w1c: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_wcs && !wb_dat_i[6] && wcs[6] |=> wcs[6])
    else $error("pin a flag cleared by zero write");
  a_flag_b_w1c: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_wcs && !wb_dat_i[7] && wcs[7] |=> wcs[7])
    else $error("pin b flag cleared by zero write");
  a_flag_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_wcs && wb_dat_i[6] && !(pin_a_act && wcs[0]) |=> !wcs[6])
    else $error("pin a flag not cleared by one");
  a_pin_a_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    pin_a_act && wcs[uswc_pkg::WCS_PIN_A_EN] |=> wcs[6])
    else $error("pin a flag not set");
  a_pin_b_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    pin_b_act && wcs[uswc_pkg::WCS_PIN_B_EN] |=> wcs[7])
    else $error("pin b flag not set");
  a_flag_a_cause: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(wcs[6]) |-> $past(pin_a_act))
    else $error("pin a flag without pin");
  a_flag_b_cause: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(wcs[7]) |-> $past(pin_b_act))
    else $error("pin b flag without pin");
  a_pol_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_wcs |=> wcs[5:4] == $past(wb_dat_i[5:4]))
    else $error("polarity write lost");
  a_en_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_wcs |=> wcs[2:0] == $past(wb_dat_i[2:0]))
    else $error("enable write lost");
  a_wcs_bit3: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !wcs[3])
    else $error("reserved wake bit set");
  a_idle_wake: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == uswc_pkg::USWC_IDLE && suspend_cond && wake_ev
    |=> state == uswc_pkg::USWC_PLL_WAIT)
    else $error("wake event ignored in idle");
  a_off_wake: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == uswc_pkg::USWC_OSC_OFF && wake_ev && wake_irq_enable
    |=> osc_enable_o && state == uswc_pkg::USWC_PLL_WAIT)
    else $error("oscillator not restarted on wake");
  a_osc_state: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state == uswc_pkg::USWC_OSC_OFF) == !osc_enable_o)
    else $error("oscillator enable out of step");
  a_cpu_rst_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == uswc_pkg::USWC_RUN && cpu_in_reset_i && bus_suspend && !src_live && !idle_set
    |=> !osc_enable_o)
    else $error("oscillator kept with cpu in reset");
  a_idle_entry: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    idle_set && state == uswc_pkg::USWC_RUN |=> cpu_idle_o)
    else $error("idle not entered");
  a_idle_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == uswc_pkg::USWC_OSC_OFF |-> cpu_idle_o)
    else $error("cpu running while stopped");
  a_only_wake: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(cpu_idle_o) |-> $past(wake_fire || instant_wake))
    else $error("idle left without wake");
  a_instant_wake: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    instant_wake |=> wake_irq_flag ##1 !cpu_idle_o)
    else $error("idle without suspend did not wake");
  a_flag_clr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_clr && !wake_fire && !instant_wake |=> !wake_irq_flag)
    else $error("wake flag not cleared");
  a_resume_k: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    drive_resume |=> usb_line_oe_o && usb_negative_line_o && !usb_positive_line_o)
    else $error("resume not driving K");
  a_release_lines: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !drive_resume |=> !usb_line_oe_o)
    else $error("lines not released");
  a_ack_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_exit_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == uswc_pkg::USWC_OSC_OFF && !wake_irq_enable && !cpu_in_reset_i
    |=> state == uswc_pkg::USWC_OSC_OFF)
    else $error("left suspend with wake irq disabled");
  c_bus_suspend: cover property (@(posedge mclk_i) $rose(susp_irq_flag));
  c_osc_off: cover property (@(posedge mclk_i) $fell(osc_enable_o));
  c_wake: cover property (@(posedge mclk_i) $rose(wake_irq_o));
  c_pin_wake: cover property (@(posedge mclk_i) $rose(wcs[6]));
  c_resume: cover property (@(posedge mclk_i) $rose(usb_line_oe_o));
endmodule
`default_nettype wire

// ==== tb/uswc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module uswc_host_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic suspend_i,
  input wire logic line_oe_i,
  input wire logic dp_i,
  input wire logic dm_i,
  output logic bus_idle_o,
  output logic dp_o,
  output logic resume_seen_o
);
  logic host_dp;
  // The device wins the wire while it drives resume
  assign dp_o = line_oe_i ? dp_i : host_dp;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_idle_o <= 1'b0;
      host_dp <= 1'b0;
      resume_seen_o <= 1'b0;
    end else begin
      bus_idle_o <= suspend_i;
      // J held while suspended, otherwise traffic toggles the line
      host_dp <= suspend_i ? 1'b1 : ~host_dp;
      if (line_oe_i && !dp_i && dm_i) begin
        resume_seen_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/uswc_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module uswc_top_bench;
  localparam logic [17:0] BCS = uswc_pkg::ADDR_BUS_CTRL_STATUS;
  localparam logic [17:0] FS = uswc_pkg::ADDR_FORCE_SUSPEND;
  localparam logic [17:0] WCS = uswc_pkg::ADDR_WAKE_CTRL_STATUS;
  localparam logic [17:0] PCTL = uswc_pkg::ADDR_POWER_CTRL;
  localparam logic [17:0] EIC = uswc_pkg::ADDR_EXT_IRQ_CTRL;
  localparam logic [17:0] PST = uswc_pkg::ADDR_POWER_STATUS;
  localparam int OSC = 0, WIRQ = 1, UIRQ = 2, IDL = 3;
  logic mclk_i = 0, rst_b_i = 0, cyc = 0, stb = 0, we = 0;
  logic [17:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic pin_a = 1, pin_b = 1, cpu_rst = 0, pll = 1, host_susp = 0;
  logic ack, bus_idle, dp_wire, uirq, wirq, osc, idle, dp, dm, oe, res_seen;
  logic [7:0] uvec, wvec, q;
  int fail_count = 0, n_tests = 0, cycles = 0;
  always #5 mclk_i = ~mclk_i;
  uswc_top #(.SUSPEND_CYC(20), .PLL_LOCK_CYC(4)) u_uswc_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .bus_idle_i(bus_idle),
    .usb_positive_line_i(dp_wire), .pin_a_i(pin_a), .pin_b_i(pin_b), .cpu_in_reset_i(cpu_rst),
    .pll_locked_i(pll), .usb_irq_line_o(uirq), .usb_irq_vector_o(uvec), .wake_irq_o(wirq),
    .wake_vector_o(wvec), .osc_enable_o(osc), .cpu_idle_o(idle), .usb_positive_line_o(dp),
    .usb_negative_line_o(dm), .usb_line_oe_o(oe));
  uswc_host_model u_uswc_host_model (.clk_i(mclk_i), .rst_b_i(rst_b_i), .suspend_i(host_susp),
    .line_oe_i(oe), .dp_i(dp), .dm_i(dm), .bus_idle_o(bus_idle), .dp_o(dp_wire),
    .resume_seen_o(res_seen));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Sized to the whole sequence with ample margin
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0000_00, d};
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    chk("ack", ack, 1);
    q = rdat[7:0];
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    wb(0, a, 8'h00);
    chk("read", q, e);
  endtask
  function automatic logic pick(input int s);
    case (s)
      OSC: return osc;
      WIRQ: return wirq;
      UIRQ: return uirq;
      default: return idle;
    endcase
  endfunction
  task automatic waitv(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    chk("wait", pick(s), v);
  endtask
  task automatic hold(input int s, input logic v, input int n);
    repeat (n) begin
      @(posedge mclk_i);
      chk("hold", pick(s), v);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1;
    rd(WCS, 8'h05);
    chk("wvec", wvec, 8'h33);
    rd(18'h0_0100, 8'h00);
    wb(1, WCS, 8'h30);
    rd(WCS, 8'h30);
    wb(1, WCS, 8'h07);
    rd(WCS, 8'h07);
    wb(1, WCS, 8'h05);
    wb(1, EIC, 8'h20);
    wb(1, PCTL, 8'h01);
    waitv(WIRQ, 1, 4);
    waitv(IDL, 0, 4);
    rd(EIC, 8'h30);
    wb(1, EIC, 8'h20);
    waitv(WIRQ, 0, 3);
    host_susp <= 1;
    hold(UIRQ, 0, 18);
    waitv(UIRQ, 1, 6);
    chk("uvec", uvec, 8'h03);
    pll <= 0;
    wb(1, PCTL, 8'h01);
    waitv(OSC, 0, 8);
    hold(IDL, 1, 3);
    host_susp <= 0;
    waitv(OSC, 1, 8);
    hold(WIRQ, 0, 6);
    pll <= 1;
    waitv(WIRQ, 1, 10);
    rd(WCS, 8'h05);
    wb(1, EIC, 8'h20);
    wb(1, PST, 8'h01);
    // Line wake off, as host traffic toggles D+ while the bus is active
    wb(1, WCS, 8'h01);
    wb(1, FS, 8'h5a);
    wb(1, PCTL, 8'h01);
    waitv(OSC, 0, 8);
    pin_a <= 0;
    waitv(OSC, 1, 8);
    waitv(WIRQ, 1, 12);
    pin_a <= 1;
    rd(WCS, 8'h41);
    wb(1, WCS, 8'h01);
    rd(WCS, 8'h41);
    wb(1, WCS, 8'h41);
    rd(WCS, 8'h01);
    wb(1, WCS, 8'h11);
    rd(WCS, 8'h51);
    wb(1, WCS, 8'h01);
    wb(1, WCS, 8'h41);
    rd(WCS, 8'h01);
    wb(1, EIC, 8'h20);
    pin_b <= 0;
    wb(1, FS, 8'h00);
    wb(1, PCTL, 8'h01);
    hold(OSC, 1, 10);
    pin_b <= 1;
    waitv(OSC, 0, 8);
    pin_a <= 0;
    waitv(WIRQ, 1, 12);
    pin_a <= 1;
    rd(WCS, 8'h41);
    wb(1, WCS, 8'h41);
    wb(1, EIC, 8'h00);
    wb(1, FS, 8'h00);
    wb(1, PCTL, 8'h01);
    waitv(OSC, 0, 8);
    pin_a <= 0;
    hold(OSC, 0, 20);
    pin_a <= 1;
    rst_b_i <= 0;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1;
    rd(WCS, 8'h05);
    cpu_rst <= 1;
    host_susp <= 1;
    waitv(OSC, 0, 30);
    host_susp <= 0;
    waitv(OSC, 1, 12);
    cpu_rst <= 0;
    // Resume after the CPU-in-reset wake, which line activity caused, and check K at the host
    wb(1, BCS, 8'h01);
    repeat (2) @(posedge mclk_i);
    chk("k_state", {oe, dp, dm}, 3'b101);
    chk("host_k", res_seen, 1);
    wb(1, BCS, 8'h00);
    repeat (2) @(posedge mclk_i);
    chk("release", oe, 0);
    close_out();
  end
endmodule
`default_nettype wire
